// *** src/ret_rot_pkg.sv ***
// Package for the return and rotate execution block.
// Assumes an 8-bit data path and a program counter of configurable width.
package ret_rot_pkg;

  // ----------------------------------------------------------------------
  // Operation codes presented by decode
  // ----------------------------------------------------------------------
  localparam logic [3:0] OP_NONE = 4'h0;
  localparam logic [3:0] OP_SUBROUTINE_EXIT = 4'h1;
  localparam logic [3:0] OP_SUBROUTINE_EXIT_LOAD_IMMEDIATE = 4'h2;
  localparam logic [3:0] OP_INTERRUPT_EXIT = 4'h3;
  localparam logic [3:0] OP_ROTATE_LEFT = 4'h4;
  localparam logic [3:0] OP_ROTATE_LEFT_TO_WORKING = 4'h5;
  localparam logic [3:0] OP_ROTATE_LEFT_VIA_CARRY = 4'h6;
  localparam logic [3:0] OP_ROTATE_LEFT_VIA_CARRY_TO_WORKING = 4'h7;
  localparam logic [3:0] OP_ROTATE_RIGHT = 4'h8;
  localparam logic [3:0] OP_ROTATE_RIGHT_TO_WORKING = 4'h9;
  localparam logic [3:0] OP_ROTATE_RIGHT_VIA_CARRY = 4'ha;
  localparam logic [3:0] OP_ROTATE_RIGHT_VIA_CARRY_TO_WORKING = 4'hb;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int BYTE_MSB = 7;
  localparam int BYTE_LSB = 0;
  localparam logic [7:0] WORKING_RESET = 8'h00;
  localparam logic CARRY_RESET = 1'b0;
  localparam logic GIE_RESET = 1'b0;

  // ----------------------------------------------------------------------
  // Execution states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_DONE = 3'b100
  } exec_state_e;

endpackage : ret_rot_pkg

// *** src/rotate_unit.sv ***
// One-bit rotate unit for an 8-bit byte, with optional carry in the loop.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
module rotate_unit (
  input wire logic [7:0] i_data,
  input wire logic i_carry,
  input wire logic i_right,
  input wire logic i_via_carry,
  output logic [7:0] o_result,
  output logic o_carry
);

  // ----------------------------------------------------------------------
  // Rotation
  // ----------------------------------------------------------------------
  always_comb begin
    if (i_right) begin
      // Bit 0 leaves; bit 7 is refilled by old carry or by bit 0.
      o_result = {(i_via_carry ? i_carry : i_data[ret_rot_pkg::BYTE_LSB]),
                  i_data[7:1]};
      o_carry = i_via_carry ? i_data[ret_rot_pkg::BYTE_LSB] : i_carry;
    end else begin
      // Bit 7 leaves; bit 0 is refilled by old carry or by bit 7.
      o_result = {i_data[6:0],
                  (i_via_carry ? i_carry : i_data[ret_rot_pkg::BYTE_MSB])};
      o_carry = i_via_carry ? i_data[ret_rot_pkg::BYTE_MSB] : i_carry;
    end
  end

endmodule : rotate_unit

// *** src/return_and_rotate_execution.sv ***
// Return and rotate execution stage of an 8-bit processor core.
// Assumes decode presents one operation with its operands for one cycle,
// the stack supplies its top entry on a pop, and memory reads are at hand.
//
// Function
// - Subroutine exit pops PC, flags untouched.
// - Exit with immediate also loads working register.
// - Interrupt exit pops PC, sets global enable.
// - Pending interrupt served before main program resumes.
// - Rotate left, bit 7 into bit 0, memory.
// - Same left rotate, result to working register.
// - Left via carry, result back to memory.
// - Left via carry into working, carry updated.
// - Rotate right, bit 0 into bit 7, memory.
// - Same right rotate, result to working register.
// - Right via carry, result back to memory.
// - Right via carry into working, memory kept.
`timescale 1ns/10ps
module return_and_rotate_execution #(
  parameter int PC_WIDTH = 13,
  parameter int ADDR_WIDTH = 8
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  // Decode side.
  input wire logic i_op_valid,
  input wire logic [3:0] i_op_code,
  input wire logic [7:0] i_immediate,
  input wire logic [ADDR_WIDTH-1:0] i_mem_addr,
  output logic o_op_ready,
  output logic o_op_done,
  // Data memory read data for the addressed byte.
  input wire logic [7:0] i_mem_rdata,
  output logic o_mem_we,
  output logic [ADDR_WIDTH-1:0] o_mem_waddr,
  output logic [7:0] o_mem_wdata,
  // Stack.
  input wire logic [PC_WIDTH-1:0] i_stack_top,
  output logic o_stack_pop,
  // Program counter load.
  output logic o_pc_load,
  output logic [PC_WIDTH-1:0] o_pc_value,
  // Interrupt controller.
  input wire logic i_irq_pending,
  input wire logic i_gie_clear,
  output logic o_irq_take,
  // Status.
  output logic [7:0] o_working_register,
  output logic o_carry,
  output logic o_global_interrupt_enable
);

  // ----------------------------------------------------------------------
  // Operation decode helpers
  // ----------------------------------------------------------------------
  function automatic logic is_rotate(input logic [3:0] op);
    is_rotate = (op >= ret_rot_pkg::OP_ROTATE_LEFT) &&
                (op <= ret_rot_pkg::OP_ROTATE_RIGHT_VIA_CARRY_TO_WORKING);
  endfunction : is_rotate

  function automatic logic is_return(input logic [3:0] op);
    is_return = (op == ret_rot_pkg::OP_SUBROUTINE_EXIT) ||
                (op == ret_rot_pkg::OP_SUBROUTINE_EXIT_LOAD_IMMEDIATE) ||
                (op == ret_rot_pkg::OP_INTERRUPT_EXIT);
  endfunction : is_return

  function automatic logic to_working(input logic [3:0] op);
    to_working = is_rotate(op) && op[0];
  endfunction : to_working

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  ret_rot_pkg::exec_state_e state;
  ret_rot_pkg::exec_state_e next_state;
  logic [3:0] op;
  logic [3:0] next_op;
  logic [7:0] imm;
  logic [7:0] next_imm;
  logic [ADDR_WIDTH-1:0] addr;
  logic [ADDR_WIDTH-1:0] next_addr;
  logic [7:0] working;
  logic [7:0] next_working;
  logic carry;
  logic next_carry;
  logic gie;
  logic next_gie;
  logic mem_we;
  logic next_mem_we;
  logic [7:0] mem_wdata;
  logic [7:0] next_mem_wdata;
  logic [ADDR_WIDTH-1:0] mem_waddr;
  logic [ADDR_WIDTH-1:0] next_mem_waddr;
  logic pc_load;
  logic next_pc_load;
  logic [PC_WIDTH-1:0] pc_value;
  logic [PC_WIDTH-1:0] next_pc_value;
  logic irq_take;
  logic next_irq_take;
  logic op_done;
  logic next_op_done;

  logic [7:0] rot_result;
  logic rot_carry;

  // The rotate flavour is read straight from the code bits: bit 3 right,
  // bit 1 through carry, bit 0 working-register destination.
  rotate_unit u_rotate (
    .i_data(i_mem_rdata),
    .i_carry(carry),
    .i_right(op[3]),
    .i_via_carry(op[1]),
    .o_result(rot_result),
    .o_carry(rot_carry)
  );

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_op = op;
    next_imm = imm;
    next_addr = addr;
    next_working = working;
    next_carry = carry;
    next_gie = gie;
    next_mem_we = 1'b0;
    next_mem_wdata = mem_wdata;
    next_mem_waddr = mem_waddr;
    next_pc_load = 1'b0;
    next_pc_value = pc_value;
    next_irq_take = 1'b0;
    next_op_done = 1'b0;
    if (i_gie_clear) begin
      next_gie = 1'b0;
    end
    case (state)
      ret_rot_pkg::ST_IDLE: begin
        if (i_op_valid && (is_rotate(i_op_code) || is_return(i_op_code))) begin
          next_op = i_op_code;
          next_imm = i_immediate;
          next_addr = i_mem_addr;
          next_state = ret_rot_pkg::ST_EXEC;
        end
      end
      ret_rot_pkg::ST_EXEC: begin
        next_state = ret_rot_pkg::ST_DONE;
        next_op_done = 1'b1;
        if (is_return(op)) begin
          // Stack top becomes the PC; the carry flag is not touched.
          next_pc_load = 1'b1;
          next_pc_value = i_stack_top;
          if (op == ret_rot_pkg::OP_SUBROUTINE_EXIT_LOAD_IMMEDIATE) begin
            next_working = imm;
          end
          if (op == ret_rot_pkg::OP_INTERRUPT_EXIT) begin
            // Set wins over a simultaneous clear from the controller.
            next_gie = 1'b1;
            // A pending request is taken right away, so its handler runs
            // before the first main-program instruction at the restored PC.
            next_irq_take = i_irq_pending;
          end
        end else begin
          next_carry = rot_carry;
          if (to_working(op)) begin
            // Memory is not written for working-register destinations.
            next_working = rot_result;
          end else begin
            next_mem_we = 1'b1;
            next_mem_waddr = addr;
            next_mem_wdata = rot_result;
          end
        end
      end
      ret_rot_pkg::ST_DONE: begin
        next_state = ret_rot_pkg::ST_IDLE;
      end
      default: begin
        next_state = ret_rot_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state <= ret_rot_pkg::ST_IDLE;
      op <= ret_rot_pkg::OP_NONE;
      imm <= 8'h00;
      addr <= '0;
      working <= ret_rot_pkg::WORKING_RESET;
      carry <= ret_rot_pkg::CARRY_RESET;
      gie <= ret_rot_pkg::GIE_RESET;
      mem_we <= 1'b0;
      mem_wdata <= 8'h00;
      mem_waddr <= '0;
      pc_load <= 1'b0;
      pc_value <= '0;
      irq_take <= 1'b0;
      op_done <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      imm <= next_imm;
      addr <= next_addr;
      working <= next_working;
      carry <= next_carry;
      gie <= next_gie;
      mem_we <= next_mem_we;
      mem_wdata <= next_mem_wdata;
      mem_waddr <= next_mem_waddr;
      pc_load <= next_pc_load;
      pc_value <= next_pc_value;
      irq_take <= next_irq_take;
      op_done <= next_op_done;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign o_op_ready = (state == ret_rot_pkg::ST_IDLE);
  // Pop is issued in the cycle the stack top is consumed.
  assign o_stack_pop = (state == ret_rot_pkg::ST_EXEC) && is_return(op);
  assign o_op_done = op_done;
  assign o_mem_we = mem_we;
  assign o_mem_waddr = mem_waddr;
  assign o_mem_wdata = mem_wdata;
  assign o_pc_load = pc_load;
  assign o_pc_value = pc_value;
  assign o_irq_take = irq_take;
  assign o_working_register = working;
  assign o_carry = carry;
  assign o_global_interrupt_enable = gie;

endmodule : return_and_rotate_execution

// *** verif/rr_sva.sv ***
// Checker for the return and rotate stage, bound to the stage's ports.
// Assumes decode holds its operands steady while an operation runs.
`timescale 1ns/10ps
module rr_sva #(
  parameter int PC_WIDTH = 13
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_op_valid,
  input wire logic [3:0] i_op_code,
  input wire logic [7:0] i_immediate,
  input wire logic [7:0] i_mem_rdata,
  input wire logic [PC_WIDTH-1:0] i_stack_top,
  input wire logic i_irq_pending,
  input wire logic o_op_ready,
  input wire logic o_op_done,
  input wire logic o_mem_we,
  input wire logic [7:0] o_mem_wdata,
  input wire logic o_stack_pop,
  input wire logic o_pc_load,
  input wire logic [PC_WIDTH-1:0] o_pc_value,
  input wire logic o_irq_take,
  input wire logic [7:0] o_working_register,
  input wire logic o_carry,
  input wire logic o_global_interrupt_enable
);
  // ----------------------------------------------------------------------
  // Operation pipeline and expected rotate result
  // ----------------------------------------------------------------------
  logic take;
  logic via;
  logic exp_c;
  logic cq;
  logic [3:0] op1;
  logic [3:0] op2;
  logic [7:0] rd_q;
  logic [7:0] exp_b;
  assign take = i_op_valid && o_op_ready && i_op_code != 4'h0 && i_op_code < 4'hc;
  assign via = op2[3:1] == 3'h3 || op2[3:1] == 3'h5;
  assign exp_c = (op2[3:1] == 3'h3) ? rd_q[7] : rd_q[0];
  always_ff @(posedge i_mclk) begin
    op1 <= (take && !i_srst) ? i_op_code : 4'h0;
    op2 <= i_srst ? 4'h0 : op1;
    rd_q <= i_mem_rdata;
    cq <= o_carry;
  end
  always_comb begin
    case (op2[3:1])
      3'h2: exp_b = {rd_q[6:0], rd_q[7]};
      3'h3: exp_b = {rd_q[6:0], cq};
      3'h4: exp_b = {rd_q[0], rd_q[7:1]};
      default: exp_b = {cq, rd_q[7:1]};
    endcase
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  a_done_timing: assert property (take |=> !o_op_done ##1 o_op_done)
    else $error("done not two cycles after take");
  a_pop_on_return: assert property (
      take && i_op_code inside {[4'h1:4'h3]} |=> o_stack_pop)
    else $error("no stack pop on return");
  a_pc_from_stack: assert property (
      o_stack_pop |=> o_pc_load && o_pc_value == $past(i_stack_top))
    else $error("pc not loaded from stack");
  a_imm_loaded: assert property (
      op2 == 4'h2 |-> o_working_register == $past(i_immediate, 2))
    else $error("immediate not loaded");
  a_gie_set: assert property (op2 == 4'h3 |-> o_global_interrupt_enable)
    else $error("global enable not set");
  a_irq_served: assert property (
      op2 == 4'h3 && $past(i_irq_pending) |-> o_irq_take && o_pc_load)
    else $error("pending interrupt not taken");
  a_ret_flag_kept: assert property (
      op2 inside {[4'h1:4'h3]} |-> o_carry == cq)
    else $error("carry changed by return");
  a_mem_result: assert property (
      op2 >= 4'h4 && !op2[0] |-> o_mem_we && o_mem_wdata == exp_b)
    else $error("wrong memory rotate");
  a_work_result: assert property (
      op2 >= 4'h4 && op2[0] |-> !o_mem_we && o_working_register == exp_b)
    else $error("wrong working rotate");
  a_carry_rotate: assert property (
      op2 >= 4'h4 |-> o_carry == (via ? exp_c : cq))
    else $error("wrong carry after rotate");
  c_irq_exit: cover property (op2 == 4'h3 && o_irq_take);
  c_via_work: cover property (op2 == 4'hb);
  c_pop: cover property (o_stack_pop);
endmodule : rr_sva

bind return_and_rotate_execution rr_sva #(.PC_WIDTH(PC_WIDTH)) u_rr_sva (
  .i_mclk(i_mclk), .i_srst(i_srst), .i_op_valid(i_op_valid), .i_op_code(i_op_code),
  .i_immediate(i_immediate), .i_mem_rdata(i_mem_rdata), .i_stack_top(i_stack_top),
  .i_irq_pending(i_irq_pending), .o_op_ready(o_op_ready), .o_op_done(o_op_done),
  .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata), .o_stack_pop(o_stack_pop),
  .o_pc_load(o_pc_load), .o_pc_value(o_pc_value), .o_irq_take(o_irq_take),
  .o_working_register(o_working_register), .o_carry(o_carry),
  .o_global_interrupt_enable(o_global_interrupt_enable));

// *** verif/rr_mem_model.sv ***
// Data memory and return stack that face the stage.
// Assumes the read address is held for the whole operation.
`timescale 1ns/10ps
module rr_mem_model (
  input wire logic i_mclk,
  input wire logic [7:0] i_addr,
  input wire logic i_we,
  input wire logic [7:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic i_pop,
  output logic [7:0] o_rdata,
  output logic [12:0] o_stack_top
);
  logic [7:0] mem [256];
  logic [12:0] pops = 13'h0;
  // The stack top steps on each pop, so a stale top is seen as a wrong address.
  assign o_rdata = mem[i_addr];
  assign o_stack_top = 13'h100 + pops;
  always @(posedge i_mclk) begin
    if (i_we) mem[i_waddr] <= i_wdata;
    if (i_pop) pops <= pops + 13'h1;
  end
endmodule : rr_mem_model

// *** verif/return_and_rotate_execution_tb.sv ***
// Testbench for the return and rotate stage.
// Assumes the memory model and the bound checker sit beside the stage.
`timescale 1ns/10ps
module return_and_rotate_execution_tb;
  typedef struct {logic [3:0] op; logic [7:0] din; logic [7:0] res; logic c;} row_s;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic i_op_valid = 1'b0;
  logic i_irq_pending = 1'b0;
  logic i_gie_clear = 1'b0;
  logic [3:0] i_op_code = 4'h0;
  logic [7:0] i_immediate = 8'h00;
  logic [7:0] i_mem_addr = 8'h00;
  logic [7:0] i_mem_rdata, o_mem_waddr, o_mem_wdata, o_working_register, w0;
  logic [12:0] i_stack_top, o_pc_value;
  logic o_op_ready, o_op_done, o_mem_we, o_stack_pop, o_pc_load, o_irq_take;
  logic o_carry, o_global_interrupt_enable, took, pcl;
  int n_errors = 0;
  int n_checks = 0;
  // Carry runs on from row to row, so the order of the rows matters.
  row_s rows [8] = '{'{4'h4, 8'h81, 8'h03, 1'b0}, '{4'h5, 8'h81, 8'h03, 1'b0},
    '{4'h6, 8'h80, 8'h00, 1'b1}, '{4'h8, 8'h01, 8'h80, 1'b1}, '{4'h9, 8'h02, 8'h01, 1'b1},
    '{4'h7, 8'h01, 8'h03, 1'b0}, '{4'ha, 8'h01, 8'h00, 1'b1}, '{4'hb, 8'h03, 8'h81, 1'b1}};
  return_and_rotate_execution u_return_and_rotate_execution (.i_mclk(i_mclk), .i_srst(i_srst),
    .i_op_valid(i_op_valid), .i_op_code(i_op_code), .i_immediate(i_immediate),
    .i_mem_addr(i_mem_addr), .o_op_ready(o_op_ready), .o_op_done(o_op_done),
    .i_mem_rdata(i_mem_rdata), .o_mem_we(o_mem_we), .o_mem_waddr(o_mem_waddr),
    .o_mem_wdata(o_mem_wdata), .i_stack_top(i_stack_top), .o_stack_pop(o_stack_pop),
    .o_pc_load(o_pc_load), .o_pc_value(o_pc_value), .i_irq_pending(i_irq_pending),
    .i_gie_clear(i_gie_clear), .o_irq_take(o_irq_take), .o_carry(o_carry),
    .o_working_register(o_working_register),
    .o_global_interrupt_enable(o_global_interrupt_enable));
  rr_mem_model u_mem (.i_mclk(i_mclk), .i_addr(i_mem_addr), .i_we(o_mem_we),
    .i_waddr(o_mem_waddr), .i_wdata(o_mem_wdata), .i_pop(o_stack_pop),
    .o_rdata(i_mem_rdata), .o_stack_top(i_stack_top));
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic print_verdict();
    if (n_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  task automatic check(input string nm, input logic [12:0] exp, input logic [12:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic do_op(input logic [3:0] op, input logic [7:0] imm, input logic [7:0] adr);
    int k;
    @(posedge i_mclk);
    i_op_valid <= 1'b1;
    i_op_code <= op;
    i_immediate <= imm;
    i_mem_addr <= adr;
    @(posedge i_mclk);
    i_op_valid <= 1'b0;
    for (k = 0; k < 6; k++) begin
      @(negedge i_mclk);
      if (o_op_done === 1'b1) break;
    end
    if (k == 6) begin
      n_errors++;
      print_verdict();
    end
    took = o_irq_take;
    pcl = o_pc_load;
    @(negedge i_mclk);
  endtask : do_op
  initial begin
    forever #2.5 i_mclk = ~i_mclk;
  end
  initial begin
    repeat (20) @(posedge i_mclk);
    i_srst <= 1'b0;
    @(negedge i_mclk);
    check("ready", 13'h1, 13'(o_op_ready));
    check("state", 13'h0, {3'h0, o_working_register, o_carry, o_global_interrupt_enable});
    for (int r = 0; r < 8; r++) begin
      u_mem.mem[r] = rows[r].din;
      w0 = o_working_register;
      do_op(rows[r].op, 8'h00, 8'(r));
      check("work", 13'(rows[r].op[0] ? rows[r].res : w0),
        13'(o_working_register));
      check("mem", 13'(rows[r].op[0] ? rows[r].din : rows[r].res),
        13'(u_mem.mem[r]));
      check("carry", 13'(rows[r].c), 13'(o_carry));
    end
    do_op(ret_rot_pkg::OP_SUBROUTINE_EXIT, 8'h00, 8'h00);
    check("pc", 13'h100, {pcl ? o_pc_value : 13'h1fff});
    do_op(ret_rot_pkg::OP_SUBROUTINE_EXIT_LOAD_IMMEDIATE, 8'h5a, 8'h00);
    check("pc imm", 13'h101, o_pc_value);
    check("imm", 13'h5a, 13'(o_working_register));
    check("carry kept", 13'h1, 13'(o_carry));
    @(posedge i_mclk);
    i_irq_pending <= 1'b1;
    do_op(ret_rot_pkg::OP_INTERRUPT_EXIT, 8'h00, 8'h00);
    check("gie", 13'h1, 13'(o_global_interrupt_enable));
    check("irq take", 13'h1, 13'(took));
    check("pc irq", 13'h102, o_pc_value);
    @(posedge i_mclk);
    i_gie_clear <= 1'b1;
    i_irq_pending <= 1'b0;
    @(posedge i_mclk);
    i_gie_clear <= 1'b0;
    @(negedge i_mclk);
    check("gie clear", 13'h0, 13'(o_global_interrupt_enable));
    do_op(ret_rot_pkg::OP_INTERRUPT_EXIT, 8'h00, 8'h00);
    check("no take", 13'h0, 13'(took));
    check("gie again", 13'h1, 13'(o_global_interrupt_enable));
    check("flags", 13'h1, 13'(o_carry));
    // A code outside the table must leave the stage idle.
    @(posedge i_mclk);
    i_op_valid <= 1'b1;
    i_op_code <= 4'hc;
    @(posedge i_mclk);
    i_op_valid <= 1'b0;
    @(negedge i_mclk);
    check("unknown code", 13'h1, 13'(o_op_ready));
    print_verdict();
  end
endmodule : return_and_rotate_execution_tb
